// file: i2c_dev_port.sv
// device end of the two-wire register port: bus engine on link_clk, register access on clk
`timescale 1ns/10ps
`include "i2c_link_defines.svh"

module i2c_dev_port (
	input  logic        clk,
	input  logic        rst_n,
	input  logic        link_clk,
	i2c_link_if.dev     bus,
	output logic        wr_valid,
	output logic [7:0]  wr_addr,
	output logic [7:0]  wr_data,
	output logic [7:0]  rd_addr,
	input  logic [7:0]  rd_data
);

	function automatic logic [7:0] ptr_next(input logic [7:0] p);
		return (p == `REG_PTR_TOP) ? p : p + 8'h01;
	endfunction : ptr_next

	// link_clk domain
	logic [1:0]                 scl_sy_q;
	logic [1:0]                 sda_sy_q;
	logic                       scl_p_q;
	logic                       sda_p_q;
	logic                       start_hi_q;
	i2c_link_pkg::dev_state_e   state_q;
	i2c_link_pkg::dev_state_e   ack_next_q;
	logic [3:0]                 cnt_q;
	logic [7:0]                 shift_q;
	logic                       drive_q;
	logic                       nack_q;
	logic [7:0]                 ptr_q;
	logic                       rep_q;
	logic [7:0]                 wr_addr_l_q;
	logic [7:0]                 wr_data_l_q;
	logic                       wr_tgl_q;
	logic [7:0]                 req_addr_q;
	logic                       req_tgl_q;
	logic                       pend_q;
	logic                       refresh_q;
	logic [1:0]                 ack_sy_q;
	logic [7:0]                 rdata_q;
	// clk domain
	logic [1:0]                 rq_sy_q;
	logic                       rq_p_q;
	logic                       cap_q;
	logic [7:0]                 fetch_q;
	logic                       ack_tgl_q;
	logic [7:0]                 rd_addr_q;
	logic [1:0]                 wr_sy_q;
	logic                       wr_p_q;
	logic                       wr_valid_q;
	logic [7:0]                 wr_addr_q;
	logic [7:0]                 wr_data_q;

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic rx_state;
	logic rx_done;
	logic tx_done;
	logic addr_hit;
	logic rd_hit;

	// both lines are pins from the master's clock domain
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sy_q <= 2'b11;
			sda_sy_q <= 2'b11;
			scl_p_q  <= 1'b1;
			sda_p_q  <= 1'b1;
		end else begin
			scl_sy_q <= {scl_sy_q[0], bus.scl};
			sda_sy_q <= {sda_sy_q[0], bus.sda};
			scl_p_q  <= scl_sy_q[1];
			sda_p_q  <= sda_sy_q[1];
		end
	end

	assign scl_s    = scl_sy_q[1];
	assign sda_s    = sda_sy_q[1];
	assign scl_rise = scl_s && !scl_p_q;
	assign scl_fall = !scl_s && scl_p_q;
	// data edges with clock steady high are control conditions, never bits
	assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_ev  = scl_s && scl_p_q && !sda_p_q && sda_s && !start_hi_q;
	assign rx_state = (state_q == i2c_link_pkg::DEV_ADDR) || (state_q == i2c_link_pkg::DEV_PTR) ||
			(state_q == i2c_link_pkg::DEV_WDATA);
	assign rx_done  = rx_state && scl_fall && (cnt_q == `BYTE_BITS);
	assign tx_done  = (state_q == i2c_link_pkg::DEV_RDATA) && scl_fall && (cnt_q == `TX_LAST_BIT);
	assign addr_hit = (shift_q[7:1] == `DEV_ADDR7);
	assign rd_hit   = (state_q == i2c_link_pkg::DEV_ADDR) && rx_done && addr_hit &&
			(shift_q[0] == `RW_READ);

	// a STOP inside the high pulse that carried a START is not honoured
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_hi_q <= 1'b0;
		end else if (start_ev) begin
			start_hi_q <= 1'b1;
		end else if (scl_fall) begin
			start_hi_q <= 1'b0;
		end
	end

	// bus engine: bits are taken on clock rise, driven on clock fall
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= i2c_link_pkg::DEV_IDLE;
			ack_next_q <= i2c_link_pkg::DEV_IDLE;
			cnt_q      <= 4'h0;
			shift_q    <= 8'h00;
			drive_q    <= 1'b0;
			nack_q     <= 1'b1;
		end else if (start_ev) begin
			state_q <= i2c_link_pkg::DEV_ADDR;
			cnt_q   <= 4'h0;
			drive_q <= 1'b0;
		end else if (stop_ev) begin
			state_q <= i2c_link_pkg::DEV_IDLE;
			drive_q <= 1'b0;
		end else begin
			unique case (state_q)
				i2c_link_pkg::DEV_IDLE, i2c_link_pkg::DEV_IGNORE: begin
					drive_q <= 1'b0;
				end
				i2c_link_pkg::DEV_ADDR, i2c_link_pkg::DEV_PTR, i2c_link_pkg::DEV_WDATA: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_s};
						cnt_q   <= cnt_q + 4'h1;
					end else if (rx_done) begin
						cnt_q <= 4'h0;
						if ((state_q == i2c_link_pkg::DEV_ADDR) && !addr_hit) begin
							state_q <= i2c_link_pkg::DEV_IGNORE;
						end else begin
							drive_q <= 1'b1;
							state_q <= i2c_link_pkg::DEV_ACK;
							if (state_q == i2c_link_pkg::DEV_ADDR) begin
								ack_next_q <= shift_q[0] ? i2c_link_pkg::DEV_RDATA :
										i2c_link_pkg::DEV_PTR;
							end else begin
								ack_next_q <= i2c_link_pkg::DEV_WDATA;
							end
						end
					end
				end
				i2c_link_pkg::DEV_ACK: begin
					if (scl_fall) begin
						state_q <= ack_next_q;
						cnt_q   <= 4'h0;
						if (ack_next_q == i2c_link_pkg::DEV_RDATA) begin
							shift_q <= rdata_q;
							drive_q <= !rdata_q[7];
						end else begin
							drive_q <= 1'b0;
						end
					end
				end
				i2c_link_pkg::DEV_RDATA: begin
					if (tx_done) begin
						drive_q <= 1'b0;
						state_q <= i2c_link_pkg::DEV_MACK;
					end else if (scl_fall) begin
						shift_q <= {shift_q[6:0], 1'b0};
						drive_q <= !shift_q[6];
						cnt_q   <= cnt_q + 4'h1;
					end
				end
				i2c_link_pkg::DEV_MACK: begin
					if (scl_rise) begin
						nack_q <= sda_s;
					end else if (scl_fall) begin
						cnt_q <= 4'h0;
						if (!nack_q) begin
							state_q <= i2c_link_pkg::DEV_RDATA;
							shift_q <= rdata_q;
							drive_q <= !rdata_q[7];
						end else begin
							state_q <= i2c_link_pkg::DEV_IGNORE;
						end
					end
				end
			endcase
		end
	end

	// open-drain: only ever pulls low, clock line is never driven
	assign bus.dev_sda_o    = 1'b0;
	assign bus.dev_sda_oe_n = !drive_q;

	// register pointer; a repeated START leaves it alone
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= `REG_PTR_RESET;
			rep_q <= 1'b0;
		end else begin
			if (start_ev) begin
				rep_q <= (state_q != i2c_link_pkg::DEV_IDLE);
			end
			if (rd_hit && !rep_q) begin
				ptr_q <= `REG_PTR_RESET;
			end else if (rx_done && (state_q == i2c_link_pkg::DEV_PTR)) begin
				ptr_q <= shift_q;
			end else if (rx_done && (state_q == i2c_link_pkg::DEV_WDATA)) begin
				ptr_q <= ptr_next(ptr_q);
			end else if (tx_done) begin
				ptr_q <= ptr_next(ptr_q);
			end
		end
	end

	// received data byte: held until the next byte, a toggle tells clk about it
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_addr_l_q <= 8'h00;
			wr_data_l_q <= 8'h00;
			wr_tgl_q    <= 1'b0;
		end else if (rx_done && (state_q == i2c_link_pkg::DEV_WDATA)) begin
			wr_addr_l_q <= ptr_q;
			wr_data_l_q <= shift_q;
			wr_tgl_q    <= !wr_tgl_q;
		end
	end

	// prefetch of the pointed register: refetched when the pointer moves or a read opens,
	// so the first bit is ready a full bus clock before it must be driven
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_addr_q <= `FETCH_TAG_RESET;
			req_tgl_q  <= 1'b0;
			pend_q     <= 1'b0;
			refresh_q  <= 1'b0;
			ack_sy_q   <= 2'b00;
			rdata_q    <= 8'h00;
		end else begin
			ack_sy_q <= {ack_sy_q[0], ack_tgl_q};
			if (pend_q) begin
				if (ack_sy_q[1] == req_tgl_q) begin
					rdata_q <= fetch_q;
					pend_q  <= 1'b0;
				end
			end else if ((req_addr_q != ptr_q) || refresh_q) begin
				req_addr_q <= ptr_q;
				req_tgl_q  <= !req_tgl_q;
				pend_q     <= 1'b1;
				refresh_q  <= 1'b0;
			end
			if (rd_hit) begin
				refresh_q <= 1'b1;
			end
		end
	end

	// clk side of the fetch: address out, data taken one clock later, toggle back
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rq_sy_q   <= 2'b00;
			rq_p_q    <= 1'b0;
			cap_q     <= 1'b0;
			fetch_q   <= 8'h00;
			ack_tgl_q <= 1'b0;
			rd_addr_q <= 8'h00;
		end else begin
			rq_sy_q <= {rq_sy_q[0], req_tgl_q};
			rq_p_q  <= rq_sy_q[1];
			cap_q   <= rq_sy_q[1] ^ rq_p_q;
			if (rq_sy_q[1] ^ rq_p_q) begin
				rd_addr_q <= req_addr_q;
			end
			if (cap_q) begin
				fetch_q   <= rd_data;
				ack_tgl_q <= !ack_tgl_q;
			end
		end
	end

	// clk side of the write: one pulse per stored byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_sy_q    <= 2'b00;
			wr_p_q     <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_addr_q  <= 8'h00;
			wr_data_q  <= 8'h00;
		end else begin
			wr_sy_q    <= {wr_sy_q[0], wr_tgl_q};
			wr_p_q     <= wr_sy_q[1];
			wr_valid_q <= wr_sy_q[1] ^ wr_p_q;
			if (wr_sy_q[1] ^ wr_p_q) begin
				wr_addr_q <= wr_addr_l_q;
				wr_data_q <= wr_data_l_q;
			end
		end
	end

	assign wr_valid = wr_valid_q;
	assign wr_addr  = wr_addr_q;
	assign wr_data  = wr_data_q;
	assign rd_addr  = rd_addr_q;

endmodule : i2c_dev_port

// file: i2c_host_port.sv
// host end of the two-wire register port: makes the bus clock and frames by command
`timescale 1ns/10ps
`include "i2c_link_defines.svh"

module i2c_host_port (
	input  logic                   clk,
	input  logic                   rst_n,
	i2c_link_if.host               bus,
	input  logic                   cmd_valid,
	output logic                   cmd_ready,
	input  i2c_link_pkg::host_op_e cmd_op,
	input  logic [7:0]             cmd_data,
	input  logic                   cmd_nack,
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_ack
);

	i2c_link_pkg::host_state_e state_q;
	logic [5:0]                qcnt_q;
	logic [1:0]                phase_q;
	logic [3:0]                bit_q;
	logic                      rd_q;
	logic                      nack_q;
	logic [7:0]                tx_q;
	logic [7:0]                rx_q;
	logic                      ackbit_q;
	logic                      scl_q;
	logic                      sda_rel_q;
	logic [1:0]                sda_sy_q;
	logic                      rsp_valid_q;
	logic [7:0]                rsp_data_q;
	logic                      rsp_ack_q;

	logic tick;
	logic step;
	logic last;
	logic accept;

	assign cmd_ready = (state_q == i2c_link_pkg::HOST_IDLE);
	assign accept    = cmd_valid && cmd_ready;
	// quarter-bit phases make the bus clock no faster than the 400kHz ceiling
	assign tick      = (qcnt_q == 6'(`SCL_QTR_CYC - 1));
	assign step      = tick && (state_q != i2c_link_pkg::HOST_IDLE);
	assign last      = step && (phase_q == 2'b11) &&
			((state_q != i2c_link_pkg::HOST_BYTE) || (bit_q == `BYTE_BITS));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qcnt_q <= 6'h00;
		end else if ((state_q == i2c_link_pkg::HOST_IDLE) || tick) begin
			qcnt_q <= 6'h00;
		end else begin
			qcnt_q <= qcnt_q + 6'h01;
		end
	end

	// device drives sda from another clock domain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_sy_q <= 2'b11;
		end else begin
			sda_sy_q <= {sda_sy_q[0], bus.sda};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= i2c_link_pkg::HOST_IDLE;
			phase_q <= 2'b00;
			bit_q   <= 4'h0;
		end else if (accept) begin
			phase_q <= 2'b00;
			bit_q   <= 4'h0;
			unique case (cmd_op)
				i2c_link_pkg::OP_START: state_q <= i2c_link_pkg::HOST_START;
				i2c_link_pkg::OP_STOP:  state_q <= i2c_link_pkg::HOST_STOP;
				i2c_link_pkg::OP_WRITE,
				i2c_link_pkg::OP_READ:  state_q <= i2c_link_pkg::HOST_BYTE;
			endcase
		end else if (last) begin
			state_q <= i2c_link_pkg::HOST_IDLE;
		end else if (step) begin
			phase_q <= phase_q + 2'b01;
			if (phase_q == 2'b11) begin
				bit_q <= bit_q + 4'h1;
			end
		end
	end

	// lines move only at phase steps; data bits only while the clock is low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q     <= 1'b1;
			sda_rel_q <= 1'b1;
		end else if (step) begin
			unique case (phase_q)
				2'b00: begin
					if (state_q == i2c_link_pkg::HOST_START) begin
						sda_rel_q <= 1'b1;
					end else if (state_q == i2c_link_pkg::HOST_STOP) begin
						sda_rel_q <= 1'b0;
					end else if (bit_q == `BYTE_BITS) begin
						sda_rel_q <= rd_q ? nack_q : 1'b1;
					end else begin
						sda_rel_q <= rd_q ? 1'b1 : tx_q[7];
					end
				end
				2'b01: scl_q <= 1'b1;
				2'b10: begin
					// START is sda falling, STOP sda rising, each in its own high pulse
					if (state_q == i2c_link_pkg::HOST_START) begin
						sda_rel_q <= 1'b0;
					end else if (state_q == i2c_link_pkg::HOST_STOP) begin
						sda_rel_q <= 1'b1;
					end
				end
				2'b11: begin
					if (state_q != i2c_link_pkg::HOST_STOP) begin
						scl_q <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_q     <= 1'b0;
			nack_q   <= 1'b1;
			tx_q     <= 8'h00;
			rx_q     <= 8'h00;
			ackbit_q <= 1'b1;
		end else if (accept) begin
			rd_q   <= (cmd_op == i2c_link_pkg::OP_READ);
			nack_q <= cmd_nack;
			tx_q   <= cmd_data;
		end else if (step && (state_q == i2c_link_pkg::HOST_BYTE)) begin
			if (phase_q == 2'b10) begin
				if (bit_q == `BYTE_BITS) begin
					ackbit_q <= sda_sy_q[1];
				end else begin
					rx_q <= {rx_q[6:0], sda_sy_q[1]};
				end
			end
			if (phase_q == 2'b11) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= 8'h00;
			rsp_ack_q   <= 1'b0;
		end else begin
			rsp_valid_q <= last;
			if (last) begin
				rsp_data_q <= rx_q;
				rsp_ack_q  <= !ackbit_q;
			end
		end
	end

	// single master: the clock is driven both ways, data only pulled low
	assign bus.host_scl_o    = scl_q;
	assign bus.host_scl_oe_n = 1'b0;
	assign bus.host_sda_o    = 1'b0;
	assign bus.host_sda_oe_n = sda_rel_q;
	assign rsp_valid         = rsp_valid_q;
	assign rsp_data          = rsp_data_q;
	assign rsp_ack           = rsp_ack_q;

endmodule : i2c_host_port

// file: i2c_link_defines.svh
// constants shared by both ends of the two-wire register link
`ifndef I2C_LINK_DEFINES_SVH
`define I2C_LINK_DEFINES_SVH

// 7-bit device address, direction bit appended as lsb
`define DEV_ADDR7          7'h4a
`define RW_WRITE           1'b0
`define RW_READ            1'b1

// pointer values
`define REG_PTR_RESET      8'h00
`define REG_PTR_TOP        8'hff
// reset value of the fetch tag, chosen unequal to REG_PTR_RESET so a first fetch happens
`define FETCH_TAG_RESET    8'hff

// bit counts within a byte
`define BYTE_BITS          4'h8
`define TX_LAST_BIT        4'h7

// timing: fastest bus clock allowed and the host's quarter-bit phase length
`define CLK_PERIOD_NS      10
`define SCL_MIN_PERIOD_NS  2500
`define SCL_QTR_CYC        ((`SCL_MIN_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))

`endif

// file: i2c_link_if.sv
// two-wire bus between host and device, with the pullup resolution of both lines
`timescale 1ns/10ps

interface i2c_link_if;
	logic scl;
	logic sda;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	logic host_scl_o;
	logic host_scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;

	// pulled high unless some enabled driver pulls low
	assign scl = (!host_scl_oe_n && !host_scl_o) ? 1'b0 : 1'b1;
	assign sda = ((!dev_sda_oe_n && !dev_sda_o) || (!host_sda_oe_n && !host_sda_o)) ? 1'b0 : 1'b1;

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe_n
	);

	modport host (
		input  sda,
		output host_scl_o,
		output host_scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n
	);
endinterface : i2c_link_if

// file: i2c_link_pkg.sv
// types shared by both ends of the two-wire register link
package i2c_link_pkg;

	typedef enum logic [2:0] {
		DEV_IDLE   = 3'b000,
		DEV_ADDR   = 3'b001,
		DEV_PTR    = 3'b010,
		DEV_WDATA  = 3'b011,
		DEV_ACK    = 3'b100,
		DEV_RDATA  = 3'b101,
		DEV_MACK   = 3'b110,
		DEV_IGNORE = 3'b111
	} dev_state_e;

	typedef enum logic [1:0] {
		HOST_IDLE  = 2'b00,
		HOST_START = 2'b01,
		HOST_STOP  = 2'b10,
		HOST_BYTE  = 2'b11
	} host_state_e;

	typedef enum logic [1:0] {
		OP_START = 2'b00,
		OP_STOP  = 2'b01,
		OP_WRITE = 2'b10,
		OP_READ  = 2'b11
	} host_op_e;

endpackage : i2c_link_pkg

// file: i2c_slave_register_port_monitor.sv
// concurrent checks on the two-wire bus between host and device ends
`timescale 1ns/10ps

module i2c_slave_register_port_monitor (
	input wire logic clk,
	input wire logic link_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic host_scl_o,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n
);
	logic [11:0] hi_q;
	logic [11:0] lo_q;

	// run lengths of the bus clock; long idle highs saturate and are excluded below
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= 12'h000;
			lo_q <= 12'h000;
		end else begin
			hi_q <= host_scl_o ? ((hi_q == 12'hfff) ? hi_q : hi_q + 12'h001) : 12'h000;
			lo_q <= host_scl_o ? 12'h000 : ((lo_q == 12'hfff) ? lo_q : lo_q + 12'h001);
		end
	end

	AST_DEV_OPEN_DRAIN: assert property (@(posedge link_clk) disable iff (!rst_n)
		dev_sda_o == 1'b0) else $error("device drives data high");
	AST_SCL_FROM_HOST: assert property (@(posedge clk) disable iff (!rst_n)
		host_scl_oe_n == 1'b0) else $error("host clock driver not enabled");
	AST_DEV_STABLE_HIGH: assert property (@(posedge link_clk) disable iff (!rst_n)
		scl && $past(scl) |-> $stable(dev_sda_oe_n)) else $error("device data moved in clock high");
	AST_STOP_RELEASE: assert property (@(posedge link_clk) disable iff (!rst_n)
		$rose(sda) && scl && $past(scl) |=> dev_sda_oe_n [*8]) else $error("device drives after stop");
	AST_START_RELEASED: assert property (@(posedge link_clk) disable iff (!rst_n)
		$fell(sda) && scl && $past(scl) |-> dev_sda_oe_n) else $error("device caused start edge");
	AST_ACK_HOLD: assert property (@(posedge link_clk) disable iff (!rst_n)
		$rose(scl) && !dev_sda_oe_n |=> !dev_sda_oe_n [*8]) else $error("device low not held");
	AST_DEV_EARLY_CHANGE: assert property (@(posedge link_clk) disable iff (!rst_n)
		$changed(dev_sda_oe_n) |-> !scl && $past(scl, 6)) else $error("device data changed late");
	AST_SCL_HIGH_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(host_scl_o) && hi_q < 12'h0c8 |-> hi_q == 12'h07e) else $error("clock high length");
	AST_SCL_LOW_LEN: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(host_scl_o) && lo_q < 12'h0c8 |-> lo_q >= 12'h07e) else $error("clock low length");
endmodule : i2c_slave_register_port_monitor

// file: i2c_slave_register_port_tb_top.sv
// self-checking bench: host end drives frames at the device end, which serves a register model
`timescale 1ns/10ps

module i2c_slave_register_port_tb_top;
	logic                   clk;
	logic                   link_clk;
	logic                   rst_n;
	logic                   cmd_valid;
	logic                   cmd_ready;
	i2c_link_pkg::host_op_e cmd_op;
	logic [7:0]             cmd_data;
	logic                   cmd_nack;
	logic                   rsp_valid;
	logic [7:0]             rsp_data;
	logic                   rsp_ack;
	logic                   wr_valid;
	logic [7:0]             wr_addr;
	logic [7:0]             wr_data;
	logic [7:0]             rd_addr;
	logic [7:0]             regs [256];
	logic [8:0]             wire_q [$];
	logic [8:0]             sh;
	int                     nbit;
	int                     wr_cnt;
	int                     n_fail;
	int                     samples_checked;
	logic [7:0]             rdat;
	logic                   rack;

	i2c_link_if bus_if ();

	i2c_dev_port i_i2c_dev_port (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .bus(bus_if),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
		.rd_data(regs[rd_addr]));

	i2c_host_port i_i2c_host_port (.clk(clk), .rst_n(rst_n), .bus(bus_if), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));

	i2c_slave_register_port_monitor i_i2c_slave_register_port_monitor (.clk(clk),
		.link_clk(link_clk), .rst_n(rst_n), .scl(bus_if.scl), .sda(bus_if.sda),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe_n(bus_if.dev_sda_oe_n),
		.host_scl_o(bus_if.host_scl_o), .host_scl_oe_n(bus_if.host_scl_oe_n),
		.host_sda_o(bus_if.host_sda_o), .host_sda_oe_n(bus_if.host_sda_oe_n));

	function automatic logic [7:0] init_val(input int i);
		init_val = 8'(i) ^ 8'hc3;
	endfunction : init_val

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// link clock phase offset keeps the two domains unrelated
	initial begin
		link_clk = 1'b0;
		#7;
		forever #15 link_clk = ~link_clk;
	end

	always @(posedge clk) begin
		if (wr_valid === 1'b1) begin
			regs[wr_addr] <= wr_data;
			wr_cnt <= wr_cnt + 1;
		end
	end

	// bus sniffer: nine clocked bits per unit, restarted by any start condition
	always @(negedge bus_if.sda) begin
		if (bus_if.scl === 1'b1)
			nbit = 0;
	end

	always @(posedge bus_if.scl) begin
		sh = {sh[7:0], bus_if.sda};
		nbit = nbit + 1;
		if (nbit == 9) begin
			wire_q.push_back(sh);
			nbit = 0;
		end
	end

	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	task automatic do_cmd(input i2c_link_pkg::host_op_e op, input logic [7:0] d, input logic nk);
		int k;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = d;
		cmd_nack = nk;
		@(negedge clk);
		cmd_valid = 1'b0;
		check("busy", {8'h00, cmd_ready}, 9'h000);
		for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++)
			@(negedge clk);
		check("response", {8'h00, rsp_valid}, 9'h001);
		rdat = rsp_data;
		rack = rsp_ack;
	endtask : do_cmd

	task automatic t_write();
		wire_q = {};
		do_cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h94, 1'b0);
		check("addr ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h10, 1'b0);
		check("ptr ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'ha5, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h5a, 1'b0);
		check("data ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
		check("reg 10", regs[8'h10], 8'ha5);
		check("reg 11", regs[8'h11], 8'h5a);
		check("stores", 9'(wr_cnt), 9'h002);
		check("wire count", 9'(wire_q.size()), 9'h004);
		check("wire addr", wire_q[0], 9'h128);
		check("wire data", wire_q[3], 9'h0b4);
	endtask : t_write

	task automatic t_read_fresh();
		wire_q = {};
		do_cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h95, 1'b0);
		check("read addr ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_READ, 8'h00, 1'b0);
		check("first read", rdat, init_val(0));
		check("host ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_READ, 8'h00, 1'b1);
		check("second read", rdat, init_val(1));
		do_cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
		check("wire last nack", wire_q[2], {init_val(1), 1'b1});
		check("idle scl", bus_if.scl, 1'b1);
		check("idle sda", bus_if.sda, 1'b1);
	endtask : t_read_fresh

	task automatic t_preset();
		do_cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h94, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'hfe, 1'b0);
		do_cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h95, 1'b0);
		check("repeat ack", rack, 1'b1);
		do_cmd(i2c_link_pkg::OP_READ, 8'h00, 1'b0);
		check("preset read", rdat, init_val(8'hfe));
		do_cmd(i2c_link_pkg::OP_READ, 8'h00, 1'b0);
		check("top read", rdat, init_val(8'hff));
		do_cmd(i2c_link_pkg::OP_READ, 8'h00, 1'b1);
		check("saturated read", rdat, init_val(8'hff));
		do_cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
	endtask : t_preset

	task automatic t_foreign();
		do_cmd(i2c_link_pkg::OP_START, 8'h00, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h96, 1'b0);
		check("foreign nack", rack, 1'b0);
		do_cmd(i2c_link_pkg::OP_WRITE, 8'h94, 1'b0);
		check("ignored byte", rack, 1'b0);
		do_cmd(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
		check("no store", 9'(wr_cnt), 9'h002);
	endtask : t_foreign

	initial begin
		for (int i = 0; i < 256; i++)
			regs[i] = init_val(i);
		n_fail = 0;
		samples_checked = 0;
		wr_cnt = 0;
		nbit = 0;
		sh = 9'h000;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = i2c_link_pkg::OP_START;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_write();
		t_read_fresh();
		t_preset();
		t_foreign();
		stop_test();
	end

	// tests need about 40000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule : i2c_slave_register_port_tb_top
